/* common/dsp_acc_pkg.sv */
package dsp_acc_pkg;

  // ==========================================
  // Widths
  localparam int STORED_WIDTH = 72;
  localparam int VIEW_WIDTH = 96;
  localparam int SLICE_WIDTH = 32;
  localparam int SIGN_BIT = 71;

  // ==========================================
  // Slice positions (low bit of each slice)
  localparam int GUARD_LSB = 64;
  localparam int HIGH_LSB = 32;
  localparam int MIDDLE_LSB = 16;
  localparam int LOW_LSB = 0;

  // ==========================================
  // Reset value
  localparam logic [71:0] ACC_RESET = 72'h0;

  // ==========================================
  // Accumulator select
  localparam logic ACC_FIRST = 1'b0;
  localparam logic ACC_SECOND = 1'b1;

  // ==========================================
  // Move-to slice codes
  typedef enum logic [1:0] {
    MOVE_TO_LOW = 2'b00,
    MOVE_TO_HIGH = 2'b01,
    MOVE_TO_GUARD = 2'b10
  } write_slice_type;

  // ==========================================
  // Move-from slice codes
  typedef enum logic [1:0] {
    MOVE_FROM_LOW = 2'b00,
    MOVE_FROM_MIDDLE = 2'b01,
    MOVE_FROM_HIGH = 2'b10,
    MOVE_FROM_GUARD = 2'b11
  } read_slice_type;

endpackage

/* verilog/dsp_accumulator_pair.sv */
// Operation
// - Two independent accumulators, first and second, each holding 72 bits.
// - Seen as 96 bits; bits 95..72 read as copies of bit 71.
// - Writes to bits 95..72 are dropped; only bits 71..0 store data.
// - Multiply and product-sum results overwrite the first accumulator.
// - Move-to writes 32 bits into guard, high or low slice.
// - Move-from reads guard, high, middle or low 32-bit slice.
`timescale 1ns/10ps
module dsp_accumulator_pair
  import dsp_acc_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Move-to request
  input wire logic WR_EN,
  input wire logic WR_SEL,
  input wire logic [1:0] WR_SLICE,
  input wire logic [31:0] WR_DATA,
  // Move-from request
  input wire logic RD_EN,
  input wire logic RD_SEL,
  input wire logic [1:0] RD_SLICE,
  // Product result into first accumulator
  input wire logic PROD_EN,
  input wire logic [71:0] PROD_DATA,
  // Move-from answer
  output logic RD_VALID,
  output logic [31:0] RD_DATA,
  // Stored state views
  output logic [71:0] FIRST_ACC,
  output logic [71:0] SECOND_ACC
);

  // ==========================================
  // Accumulator storage
  logic [71:0] acc [2];
  logic [71:0] next_acc [2];
  logic [95:0] view [2];

  // ==========================================
  // Write slice decode
  logic [95:0] wr_image;
  logic [95:0] wr_mask;
  logic slice_known;

  always_comb begin
    wr_image = '0;
    wr_mask = '0;
    slice_known = 1'h0;
    unique case (write_slice_type'(WR_SLICE))
      MOVE_TO_GUARD: begin
        wr_image[GUARD_LSB +: SLICE_WIDTH] = WR_DATA;
        wr_mask[GUARD_LSB +: SLICE_WIDTH] = '1;
        slice_known = 1'h1;
      end
      MOVE_TO_HIGH: begin
        wr_image[HIGH_LSB +: SLICE_WIDTH] = WR_DATA;
        wr_mask[HIGH_LSB +: SLICE_WIDTH] = '1;
        slice_known = 1'h1;
      end
      MOVE_TO_LOW: begin
        wr_image[LOW_LSB +: SLICE_WIDTH] = WR_DATA;
        wr_mask[LOW_LSB +: SLICE_WIDTH] = '1;
        slice_known = 1'h1;
      end
      default: begin
        wr_image = '0;
        wr_mask = '0;
        slice_known = 1'h0;
      end
    endcase
  end

  // ==========================================
  // Only bits 71..0 have storage
  logic [71:0] store_image;
  logic [71:0] store_mask;

  always_comb begin
    store_image = wr_image[STORED_WIDTH - 1:0];
    store_mask = wr_mask[STORED_WIDTH - 1:0];
  end

  // ==========================================
  // Write request
  logic wr_take;

  always_comb begin
    wr_take = WR_EN && slice_known;
  end

  // ==========================================
  // Per-accumulator request decode
  logic [1:0] wr_hit;
  logic [1:0] prod_hit;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_acc
      // Request hits
      assign wr_hit[i] = wr_take && (WR_SEL == 1'(i));
      assign prod_hit[i] = (i == 0) ? PROD_EN : 1'h0;

      // Sign-extended 96-bit view
      assign view[i] = {{(VIEW_WIDTH - STORED_WIDTH){acc[i][SIGN_BIT]}},
                        acc[i]};

      // Next stored value
      always_comb begin
        next_acc[i] = acc[i];
        if (wr_hit[i]) begin
          next_acc[i] = (acc[i] & ~store_mask)
                        | (store_image & store_mask);
        end
        if (prod_hit[i]) begin
          next_acc[i] = PROD_DATA;
        end
      end

      // Storage flops
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          acc[i] <= ACC_RESET;
        end else begin
          acc[i] <= next_acc[i];
        end
      end
    end
  endgenerate

  // ==========================================
  // Stored state views
  logic [71:0] next_first_acc;
  logic [71:0] next_second_acc;

  always_comb begin
    next_first_acc = next_acc[0];
    next_second_acc = next_acc[1];
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      FIRST_ACC <= ACC_RESET;
      SECOND_ACC <= ACC_RESET;
    end else begin
      FIRST_ACC <= next_first_acc;
      SECOND_ACC <= next_second_acc;
    end
  end

  // ==========================================
  // Read source select
  logic [95:0] rd_view;

  always_comb begin
    unique case (RD_SEL)
      ACC_SECOND: begin
        rd_view = view[1];
      end
      ACC_FIRST: begin
        rd_view = view[0];
      end
    endcase
  end

  // ==========================================
  // Read slice extract
  logic [31:0] rd_slice_data;

  always_comb begin
    unique case (read_slice_type'(RD_SLICE))
      MOVE_FROM_GUARD: begin
        rd_slice_data = rd_view[GUARD_LSB +: SLICE_WIDTH];
      end
      MOVE_FROM_HIGH: begin
        rd_slice_data = rd_view[HIGH_LSB +: SLICE_WIDTH];
      end
      MOVE_FROM_MIDDLE: begin
        rd_slice_data = rd_view[MIDDLE_LSB +: SLICE_WIDTH];
      end
      MOVE_FROM_LOW: begin
        rd_slice_data = rd_view[LOW_LSB +: SLICE_WIDTH];
      end
    endcase
  end

  // ==========================================
  // Read answer strobe
  logic next_rd_valid;

  always_comb begin
    next_rd_valid = RD_EN;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RD_VALID <= 1'h0;
    end else begin
      RD_VALID <= next_rd_valid;
    end
  end

  // ==========================================
  // Read answer data, held until next read
  logic [31:0] next_rd_data;

  always_comb begin
    next_rd_data = RD_DATA;
    if (RD_EN) begin
      next_rd_data = rd_slice_data;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RD_DATA <= 32'h0;
    end else begin
      RD_DATA <= next_rd_data;
    end
  end

endmodule

/* tb/dsp_exec_model.sv */
`timescale 1ns/10ps
module dsp_exec_model(input wire logic go,input wire logic [31:0] a,b,
  output logic PROD_EN,output logic [71:0] PROD_DATA);
  logic [71:0] p;
  // Operands only from core registers, never I/O space
  assign p={{40{a[31]}},a}*{{40{b[31]}},b};
  assign PROD_DATA=p;
  assign PROD_EN=go;
endmodule

/* tb/dsp_acc_chk_props.sv */
`timescale 1ns/10ps
module dsp_acc_chk(input wire logic CORE_CLK,SYS_RST,WR_EN,WR_SEL,RD_EN,
  RD_SEL,PROD_EN,RD_VALID,input wire logic [1:0] WR_SLICE,RD_SLICE,
  input wire logic [31:0] WR_DATA,RD_DATA,
  input wire logic [71:0] PROD_DATA,FIRST_ACC,SECOND_ACC);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  property p_ind; !(WR_EN&&WR_SEL)|=>$stable(SECOND_ACC); endproperty
  a_ind: assert property(p_ind) else $error("bad");
  property p_gd; WR_EN&&WR_SEL&&WR_SLICE==2'h2|=>
    SECOND_ACC[71:64]==$past(WR_DATA[7:0]); endproperty
  a_gd: assert property(p_gd) else $error("bad");
  property p_prd; PROD_EN|=>FIRST_ACC==$past(PROD_DATA); endproperty
  a_prd: assert property(p_prd) else $error("bad");
  property p_gr; RD_EN&&RD_SEL&&RD_SLICE==2'h3|=>
    RD_DATA==32'($signed($past(SECOND_ACC[71:64]))); endproperty
  a_gr: assert property(p_gr) else $error("bad");
  property p_mid; RD_EN&&!RD_SEL&&RD_SLICE==2'h1|=>
    RD_DATA==$past(FIRST_ACC[47:16]); endproperty
  a_mid: assert property(p_mid) else $error("bad");
  property p_vld; 1'b1|=>RD_VALID==$past(RD_EN); endproperty
  a_vld: assert property(p_vld) else $error("bad");
  property p_lo; WR_EN&&!WR_SEL&&WR_SLICE==2'h0&&!PROD_EN|=>
    FIRST_ACC[31:0]==$past(WR_DATA); endproperty
  a_lo: assert property(p_lo) else $error("bad low write");
  property p_hi; WR_EN&&!WR_SEL&&WR_SLICE==2'h1&&!PROD_EN|=>
    FIRST_ACC[63:32]==$past(WR_DATA); endproperty
  a_hi: assert property(p_hi) else $error("bad high write");
  c_pw: cover property(PROD_EN&&WR_EN);
  c_gr: cover property(RD_EN&&RD_SLICE==2'h3);
  c_b2b: cover property(RD_EN[*2]);
endmodule
bind dsp_accumulator_pair dsp_acc_chk chk(.*);

/* tb/dsp_accumulator_pair_tb_top.sv */
`timescale 1ns/10ps
module dsp_accumulator_pair_tb_top;
  `define CHK(x,e) begin total_checks++;if((x)!==(e))begin num_errors++;\
  $display("ERROR %0t %h %h",$time,x,e);end end
  typedef struct {logic s;logic [1:0] w,r;logic [31:0] d,e;} row_type;
  row_type r,rows[6]='{
    '{1'h1,2'h0,2'h0,32'h89ABCDEF,32'h89ABCDEF},
    '{1'h1,2'h2,2'h3,32'h5555557F,32'h0000007F},
    '{1'h1,2'h3,2'h0,32'hFFFFFFFF,32'h89ABCDEF},
    '{1'h0,2'h1,2'h2,32'h12345678,32'h12345678},
    '{1'h0,2'h0,2'h1,32'h9ABCDEF0,32'h56789ABC},
    '{1'h0,2'h2,2'h3,32'h000000C3,32'hFFFFFFC3}};
  logic CORE_CLK=1'h0,SYS_RST=1'h1,WR_EN=1'h0,WR_SEL=1'h0;
  logic RD_EN=1'h0,RD_SEL=1'h0,go=1'h0;
  logic RD_VALID,PROD_EN;
  logic [1:0] WR_SLICE=2'h0,RD_SLICE=2'h0;
  logic [31:0] WR_DATA=32'h0,a=32'h0,b=32'h0,RD_DATA;
  logic [71:0] PROD_DATA,FIRST_ACC,SECOND_ACC;
  int num_errors=0,total_checks=0;
  always #25 CORE_CLK=~CORE_CLK;
  dsp_exec_model pm(.go(go),.a(a),.b(b),.PROD_EN(PROD_EN),
    .PROD_DATA(PROD_DATA));
  dsp_accumulator_pair DUT(.CORE_CLK(CORE_CLK),.SYS_RST(SYS_RST),
    .WR_EN(WR_EN),.WR_SEL(WR_SEL),.WR_SLICE(WR_SLICE),.WR_DATA(WR_DATA),
    .RD_EN(RD_EN),.RD_SEL(RD_SEL),.RD_SLICE(RD_SLICE),.PROD_EN(PROD_EN),
    .PROD_DATA(PROD_DATA),.RD_VALID(RD_VALID),.RD_DATA(RD_DATA),
    .FIRST_ACC(FIRST_ACC),.SECOND_ACC(SECOND_ACC));
  task give_verdict;
    $display("checks %0d errors %0d",total_checks,num_errors);
    if(num_errors==0&&total_checks>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial #10000 begin num_errors++;give_verdict;end
  initial begin
    repeat(6) @(negedge CORE_CLK);
    SYS_RST=0;
    foreach(rows[i]) begin
      r=rows[i];
      @(negedge CORE_CLK);
      {WR_EN,WR_SEL,WR_SLICE,WR_DATA}={1'b1,r.s,r.w,r.d};
      @(negedge CORE_CLK);
      {WR_EN,RD_EN,RD_SEL,RD_SLICE}={2'h1,r.s,r.r};
      @(negedge CORE_CLK) RD_EN=0;
      `CHK({RD_VALID,RD_DATA},{1'h1,r.e})
    end
    $display("table done");
    SYS_RST=1'h1;
    @(negedge CORE_CLK);
    `CHK({FIRST_ACC,SECOND_ACC},144'h0)
    `CHK({RD_VALID,RD_DATA},33'h0)
    SYS_RST=1'h0;
    $display("reset done");
    @(negedge CORE_CLK);
    {go,a,b,WR_EN,WR_SEL,WR_SLICE,RD_EN,RD_SEL,RD_SLICE}=
      {1'h1,32'h80000000,32'h7FFFFFFF,8'h8B};
    @(negedge CORE_CLK) {go,WR_EN,RD_SLICE}=4'h1;
    `CHK({RD_VALID,RD_DATA},33'h100000000)
    @(negedge CORE_CLK) RD_SLICE=2'h3;
    `CHK(RD_DATA,32'h00008000)
    `CHK({FIRST_ACC,SECOND_ACC},{72'hFFC000000080000000,72'h0})
    @(negedge CORE_CLK) RD_EN=0;
    `CHK(RD_DATA,32'hFFFFFFFF)
    $display("product done");
    give_verdict;
  end
endmodule
